/* File: core/frc_pkg.sv */
// Shared constants and types for the filter reset and calibration link
// What this block does
// - Host keeps SCLK period at most 520 ns
// - Host waits 64 oscillator clocks between writes
// - Config writes, resync, start rise reset filter
// - Resync resets filter four clocks after bit seven
// - Input-select write always resets filter
// - Other config writes reset filter 32 modulator clocks
// - Overlapping reset pulses combine as AND
// - First conversion uses the longer first count, or the short count after input-select write or resync
// - Later conversions use the shorter steady count
// - Output is input minus offset, times gain
// - Scaled output clips to the 16-bit range
// - Correction words load by host or calibration
// - Offset word is 24-bit two's complement
// - Low offset byte gives sub-LSB correction
// - Offset extremes map to the documented codes
// - Gain word 400000h means unity scale
// - Software keeps calibration offsets in full
// - Software bounds large gain with large offset
// - Resync abandons the running conversion
// - Start rise holds filter reset 32 modulator clocks
package frc_pkg;
  localparam logic [3:0] ADDR_INSEL = 4'h0;
  localparam logic [3:0] ADDR_BIAS = 4'h1;
  localparam logic [3:0] ADDR_REFC = 4'h2;
  localparam logic [3:0] ADDR_GRATE = 4'h3;
  localparam logic [3:0] ADDR_OFC0 = 4'h4;
  localparam logic [3:0] ADDR_OFC1 = 4'h5;
  localparam logic [3:0] ADDR_OFC2 = 4'h6;
  localparam logic [3:0] ADDR_FSC0 = 4'h7;
  localparam logic [3:0] ADDR_FSC1 = 4'h8;
  localparam logic [3:0] ADDR_FSC2 = 4'h9;
  localparam logic [3:0] REGISTER_WRITE_COMMAND_HI = 4'h4;
  localparam logic [7:0] SYNC_OP = 8'h04;
  localparam logic [3:0] SYNC_BIT = 4'h7;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [2:0] SYNC_DLY = 3'h4;
  localparam logic [5:0] FRST_MOD = 6'h20;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [23:0] OFC_RST = 24'h000000;
  localparam logic [23:0] FSC_RST = 24'h400000;
  localparam logic [3:0] RATE_MAX = 4'h9;
  localparam int SCALE_SH = 30;
  localparam logic signed [19:0] CLIP_HI = 20'sh07fff;
  localparam logic signed [19:0] CLIP_LO = 20'shf8000;
  localparam logic [15:0] CODE_HI = 16'h7fff;
  localparam logic [15:0] CODE_LO = 16'h8000;
  typedef logic [19:0] frc_cnt_t;
  typedef frc_cnt_t [0:9] frc_tab_t;
  // Counts in converter clocks, rate codes 0 to 9
  localparam frc_tab_t FIRST_DEF = {20'hc8429, 20'h64a29, 20'h32d29,
    20'h192c2, 20'h0cb82, 20'h067e2, 20'h03402, 20'h01b22, 20'h01242,
    20'h00942};
  localparam frc_tab_t SHORT_DEF = {20'hc7420, 20'h63a20, 20'h31d20,
    20'h18eb8, 20'h0c778, 20'h063d8, 20'h031fc, 20'h0191c, 20'h0103c,
    20'h0083c};
  localparam frc_tab_t NEXT_DEF = {20'hc7400, 20'h63a00, 20'h31d00,
    20'h18e80, 20'h0c740, 20'h063a0, 20'h031c0, 20'h018e0, 20'h01000,
    20'h00800};
  typedef enum logic [2:0] {
    DS_OP = 3'b001, DS_CNT = 3'b010, DS_DATA = 3'b100
  } frc_dev_st_t;
  typedef enum logic [2:0] {
    HS_IDLE = 3'b001, HS_SHIFT = 3'b010, HS_GAP = 3'b100
  } frc_host_st_t;
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_DATA = 8'h04;
  localparam logic [7:0] APB_STAT = 8'h08;
  localparam logic [7:0] APB_CTRL = 8'h0c;
  localparam logic [1:0] KIND_REGISTER_WRITE_COMMAND = 2'h1;
  localparam logic [1:0] KIND_SYNC = 2'h2;
  localparam logic [1:0] CNT_MAX = 2'h2;
  localparam logic [5:0] REGISTER_WRITE_COMMAND_BITS = 6'h18;
  localparam logic [5:0] SYNC_BITS = 6'h10;
  localparam int SYS_PERIOD_NS = 8;
  localparam int SCLK_MAX_NS = 520;
  localparam int BYTE_START_MAX_NS = 4200;
  localparam int SCLK_HALF_CYC = SCLK_MAX_NS / (2 * SYS_PERIOD_NS);
  localparam int WR_GAP_OSC = 64;
  localparam int OSC_KHZ = 4096;
  localparam int WR_GAP_CYC = (WR_GAP_OSC * 1000000 +
    OSC_KHZ * SYS_PERIOD_NS - 1) / (OSC_KHZ * SYS_PERIOD_NS);
endpackage

/* File: core/frc_link_if.sv */
// Serial link between the host controller and the converter back end
`timescale 1ns/10ps
`default_nettype none
interface frc_link_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic start;
  logic drdy_n;
  modport dev (input sclk, input cs_n, input din, input start,
    output drdy_n);
  modport host (output sclk, output cs_n, output din, output start,
    input drdy_n);
endinterface // frc_link_if
`default_nettype wire

/* File: core/frc_dev.sv */
// Converter end: filter reset sequencing, conversion timing, scaling
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module frc_dev #(
  parameter int FCLK_DIV = 30,
  parameter int MOD_DIV = 16,
  parameter frc_pkg::frc_tab_t FIRST_CNT = frc_pkg::FIRST_DEF,
  parameter frc_pkg::frc_tab_t SHORT_CNT = frc_pkg::SHORT_DEF,
  parameter frc_pkg::frc_tab_t NEXT_CNT = frc_pkg::NEXT_DEF
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // Link to the host
  frc_link_if.dev LINK,
  // Filter and calibration side
  input wire logic [15:0] FILT_DATA,
  input wire logic WAKE,
  input wire logic CAL_OFS_LOAD,
  input wire logic CAL_GAIN_LOAD,
  input wire logic [23:0] CAL_VALUE,
  // Results and configuration
  output logic FILT_RST_N,
  output logic [15:0] RESULT,
  output logic RESULT_VALID,
  output logic [7:0] INPUT_SELECT,
  output logic [7:0] BIAS_VOLTAGE,
  output logic [7:0] REFERENCE_CONTROL,
  output logic [7:0] GAIN_RATE,
  output logic [23:0] OFFSET_WORD,
  output logic [23:0] GAIN_WORD
);
  if (FCLK_DIV < 1 || FCLK_DIV > 256 || MOD_DIV < 1 || MOD_DIV > 256)
  begin : g_bad_div
    $error("frc_dev: divider out of range");
  end

  localparam logic [7:0] FDIV_LAST = 8'(FCLK_DIV - 1);
  localparam logic [7:0] MDIV_LAST = 8'(MOD_DIV - 1);

  typedef struct packed {
    logic [2:0] s_sclk;
    logic [2:0] s_csn;
    logic [2:0] s_din;
    logic [2:0] s_start;
    logic sclk_f;
    logic csn_f;
    logic din_f;
    logic start_f;
    logic [7:0] fdiv;
    logic [7:0] mdiv;
    logic [7:0] sh;
    logic [3:0] bits;
    frc_pkg::frc_dev_st_t st;
    logic [3:0] addr;
    logic [7:0] left;
    logic [7:0] input_select_reg;
    logic [7:0] bias_voltage_reg;
    logic [7:0] reference_control_reg;
    logic [7:0] gain_rate_reg;
    logic [23:0] offset_correction_word;
    logic [23:0] gain_correction_word;
    logic sync_arm;
    logic [2:0] sync_dly;
    logic [5:0] rst_cnt;
    logic short_first;
    logic filt_rst_n;
    logic conv_run;
    logic [19:0] conv_cnt;
    logic drdy_n;
    logic [15:0] result;
    logic result_valid;
  } frc_dev_q_t;

  localparam frc_dev_q_t Q_RST = '{st: frc_pkg::DS_OP,
    csn_f: 1'b1, s_csn: 3'h7, drdy_n: 1'b1,
    rst_cnt: frc_pkg::FRST_MOD,
    input_select_reg: frc_pkg::CFG_RST,
    bias_voltage_reg: frc_pkg::CFG_RST,
    reference_control_reg: frc_pkg::CFG_RST,
    gain_rate_reg: frc_pkg::CFG_RST,
    offset_correction_word: frc_pkg::OFC_RST,
    gain_correction_word: frc_pkg::FSC_RST,
    default: '0};

  frc_dev_q_t q_q;
  frc_dev_q_t q_d;

  // A change counts once the last two stages agree
  function automatic logic filt(input logic [2:0] s, input logic f);
    return (s[1] == s[2]) ? s[2] : f;
  endfunction

  function automatic logic [15:0] scale(input logic [15:0] x,
    input logic [23:0] o, input logic [23:0] g);
    logic signed [24:0] d;
    logic signed [49:0] p;
    logic signed [19:0] s;
    // Full 24-bit offset keeps the sub-LSB byte
    d = $signed({x[15], x, 8'h00}) - $signed({o[23], o});
    p = d * $signed({1'b0, g});
    s = p[frc_pkg::SCALE_SH +: 20];
    // Floor shift gives FFFFh for 000100h and 8000h at 7FFFFFh
    if (s > frc_pkg::CLIP_HI) begin
      return frc_pkg::CODE_HI;
    end else if (s < frc_pkg::CLIP_LO) begin
      return frc_pkg::CODE_LO;
    end
    return s[15:0];
  endfunction

  always_comb begin
    logic ftick;
    logic mtick;
    logic fall;
    logic trig;
    logic short_trig;
    logic [7:0] byte_v;
    logic [3:0] r;
    q_d = q_q;
    q_d.result_valid = 1'b0;
    trig = 1'b0;
    short_trig = 1'b0;
    r = (q_q.gain_rate_reg[3:0] > frc_pkg::RATE_MAX) ?
      frc_pkg::RATE_MAX : q_q.gain_rate_reg[3:0];
    ftick = (q_q.fdiv == FDIV_LAST);
    q_d.fdiv = ftick ? 8'h00 : q_q.fdiv + 8'h01;
    mtick = ftick && (q_q.mdiv == MDIV_LAST);
    if (ftick) begin
      q_d.mdiv = mtick ? 8'h00 : q_q.mdiv + 8'h01;
    end
    q_d.s_sclk = {q_q.s_sclk[1:0], LINK.sclk};
    q_d.s_csn = {q_q.s_csn[1:0], LINK.cs_n};
    q_d.s_din = {q_q.s_din[1:0], LINK.din};
    q_d.s_start = {q_q.s_start[1:0], LINK.start};
    q_d.sclk_f = filt(q_q.s_sclk, q_q.sclk_f);
    q_d.csn_f = filt(q_q.s_csn, q_q.csn_f);
    q_d.din_f = filt(q_q.s_din, q_q.din_f);
    q_d.start_f = filt(q_q.s_start, q_q.start_f);
    fall = q_q.sclk_f & ~q_d.sclk_f;
    byte_v = {q_q.sh[6:0], q_d.din_f};
    // Resync delay runs on converter clocks
    if (q_q.sync_arm && ftick) begin
      if (q_q.sync_dly == frc_pkg::SYNC_DLY - 3'h1) begin
        q_d.sync_arm = 1'b0;
        trig = 1'b1;
        short_trig = 1'b1;
      end else begin
        q_d.sync_dly = q_q.sync_dly + 3'h1;
      end
    end
    // Any falling serial clock releases a pending ready flag
    if (fall) begin
      q_d.drdy_n = 1'b1;
    end
    if (q_q.csn_f) begin
      q_d.bits = 4'h0;
      q_d.st = frc_pkg::DS_OP;
    end else if (fall) begin
      q_d.sh = byte_v;
      q_d.bits = q_q.bits + 4'h1;
      if (q_q.st == frc_pkg::DS_OP && q_d.bits == frc_pkg::SYNC_BIT &&
          byte_v[6:0] == frc_pkg::SYNC_OP[7:1]) begin
        q_d.sync_arm = 1'b1;
        q_d.sync_dly = 3'h0;
      end
      if (q_d.bits == frc_pkg::BYTE_BITS) begin
        q_d.bits = 4'h0;
        case (q_q.st)
          frc_pkg::DS_OP: begin
            if (byte_v[7:4] == frc_pkg::REGISTER_WRITE_COMMAND_HI) begin
              q_d.addr = byte_v[3:0];
              q_d.st = frc_pkg::DS_CNT;
            end
          end
          frc_pkg::DS_CNT: begin
            q_d.left = byte_v;
            q_d.st = frc_pkg::DS_DATA;
          end
          frc_pkg::DS_DATA: begin
            q_d.addr = q_q.addr + 4'h1;
            if (q_q.left == 8'h00) begin
              q_d.st = frc_pkg::DS_OP;
            end else begin
              q_d.left = q_q.left - 8'h01;
            end
            // Config writes reset the filter even with an unchanged value
            case (q_q.addr)
              frc_pkg::ADDR_INSEL: begin
                q_d.input_select_reg = byte_v;
                trig = 1'b1;
                short_trig = 1'b1;
              end
              frc_pkg::ADDR_BIAS: begin
                q_d.bias_voltage_reg = byte_v;
                trig = 1'b1;
              end
              frc_pkg::ADDR_REFC: begin
                q_d.reference_control_reg = byte_v;
                trig = 1'b1;
              end
              frc_pkg::ADDR_GRATE: begin
                q_d.gain_rate_reg = byte_v;
                trig = 1'b1;
              end
              frc_pkg::ADDR_OFC0: q_d.offset_correction_word[7:0] = byte_v;
              frc_pkg::ADDR_OFC1: q_d.offset_correction_word[15:8] = byte_v;
              frc_pkg::ADDR_OFC2: q_d.offset_correction_word[23:16] = byte_v;
              frc_pkg::ADDR_FSC0: q_d.gain_correction_word[7:0] = byte_v;
              frc_pkg::ADDR_FSC1: q_d.gain_correction_word[15:8] = byte_v;
              frc_pkg::ADDR_FSC2: q_d.gain_correction_word[23:16] = byte_v;
              default: ;
            endcase
          end
          default: q_d.st = frc_pkg::DS_OP;
        endcase
      end
    end
    // Calibration results override a host byte in the same cycle
    if (CAL_OFS_LOAD) begin
      q_d.offset_correction_word = CAL_VALUE;
    end
    if (CAL_GAIN_LOAD) begin
      q_d.gain_correction_word = CAL_VALUE;
    end
    if (q_d.start_f && !q_q.start_f) begin
      trig = 1'b1;
    end
    if (WAKE) begin
      trig = 1'b1;
    end
    // Every trigger reloads the hold, so overlapping pulses merge
    if (trig) begin
      q_d.rst_cnt = frc_pkg::FRST_MOD;
      q_d.short_first = short_trig;
      q_d.conv_run = 1'b0;
      q_d.drdy_n = 1'b1;
    end else if (q_q.rst_cnt != 6'h00) begin
      if (mtick) begin
        q_d.rst_cnt = q_q.rst_cnt - 6'h01;
      end
    end else if (!q_q.conv_run) begin
      if (q_q.start_f) begin
        q_d.conv_run = 1'b1;
        q_d.conv_cnt = q_q.short_first ? SHORT_CNT[r] : FIRST_CNT[r];
      end
    end else if (ftick) begin
      if (q_q.conv_cnt == 20'h00001) begin
        q_d.result = scale(FILT_DATA, q_q.offset_correction_word,
          q_q.gain_correction_word);
        q_d.result_valid = 1'b1;
        q_d.drdy_n = 1'b0;
        q_d.conv_cnt = NEXT_CNT[r];
        // Start low means power down once this result is out
        if (!q_q.start_f) begin
          q_d.conv_run = 1'b0;
        end
      end else begin
        q_d.conv_cnt = q_q.conv_cnt - 20'h00001;
      end
    end
    q_d.filt_rst_n = (q_d.rst_cnt == 6'h00);
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      q_q <= Q_RST;
    end else begin
      q_q <= q_d;
    end
  end

  assign LINK.drdy_n = q_q.drdy_n;
  assign FILT_RST_N = q_q.filt_rst_n;
  assign RESULT = q_q.result;
  assign RESULT_VALID = q_q.result_valid;
  assign INPUT_SELECT = q_q.input_select_reg;
  assign BIAS_VOLTAGE = q_q.bias_voltage_reg;
  assign REFERENCE_CONTROL = q_q.reference_control_reg;
  assign GAIN_RATE = q_q.gain_rate_reg;
  assign OFFSET_WORD = q_q.offset_correction_word;
  assign GAIN_WORD = q_q.gain_correction_word;
endmodule // frc_dev
`default_nettype wire

/* File: core/frc_host.sv */
// Host end: APB command registers driving the serial link
`timescale 1ns/10ps
`default_nettype none
module frc_host #(
  parameter int SCLK_HALF = frc_pkg::SCLK_HALF_CYC,
  parameter int WR_GAP = frc_pkg::WR_GAP_CYC
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Link to the converter
  frc_link_if.host LINK
);
  if (SCLK_HALF < 1 || SCLK_HALF > 64 ||
      2 * SCLK_HALF * frc_pkg::SYS_PERIOD_NS > frc_pkg::SCLK_MAX_NS ||
      16 * SCLK_HALF * frc_pkg::SYS_PERIOD_NS >
      frc_pkg::BYTE_START_MAX_NS || WR_GAP < SCLK_HALF || WR_GAP > 2047)
  begin : g_bad_timing
    $error("frc_host: link timing out of range");
  end

  localparam logic [5:0] HALF_LAST = 6'(SCLK_HALF - 1);
  localparam logic [10:0] GAP_LAST = 11'(WR_GAP - 1);

  typedef struct packed {
    frc_pkg::frc_host_st_t st;
    logic [5:0] div;
    logic sclk;
    logic csn;
    logic din;
    logic start;
    logic [39:0] sh;
    logic [5:0] nbits;
    logic [10:0] gap;
    logic [9:0] cmd;
    logic [23:0] data;
    logic [2:0] s_drdy;
    logic drdy_f;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } frc_host_q_t;

  localparam frc_host_q_t Q_RST = '{st: frc_pkg::HS_IDLE, csn: 1'b1,
    s_drdy: 3'h7, drdy_f: 1'b1, default: '0};

  frc_host_q_t q_q;
  frc_host_q_t q_d;

  always_comb begin
    logic half;
    logic wr;
    logic go;
    logic busy;
    q_d = q_q;
    q_d.s_drdy = {q_q.s_drdy[1:0], LINK.drdy_n};
    q_d.drdy_f = (q_q.s_drdy[1] == q_q.s_drdy[2]) ?
      q_q.s_drdy[2] : q_q.drdy_f;
    busy = (q_q.st != frc_pkg::HS_IDLE);
    half = (q_q.div == HALF_LAST);
    // One wait state: answer is prepared, then taken on PREADY
    wr = PSEL && PENABLE && q_q.pready && PWRITE;
    go = wr && (PADDR == frc_pkg::APB_CMD);
    if (PSEL && PENABLE && !q_q.pready) begin
      q_d.pready = 1'b1;
      q_d.pslverr = 1'b0;
      case (PADDR)
        frc_pkg::APB_CMD: q_d.prdata = {22'h000000, q_q.cmd};
        frc_pkg::APB_DATA: q_d.prdata = {8'h00, q_q.data};
        frc_pkg::APB_STAT: q_d.prdata = {29'h00000000, q_q.start,
          ~q_q.drdy_f, busy};
        frc_pkg::APB_CTRL: q_d.prdata = {31'h00000000, q_q.start};
        default: begin
          q_d.prdata = 32'h00000000;
          q_d.pslverr = 1'b1;
        end
      endcase
    end else begin
      q_d.pready = 1'b0;
    end
    if (go) begin
      q_d.cmd = PWDATA[9:0];
    end
    if (wr && PADDR == frc_pkg::APB_DATA) begin
      q_d.data = PWDATA[23:0];
    end
    if (wr && PADDR == frc_pkg::APB_CTRL) begin
      q_d.start = PWDATA[0];
    end
    case (q_q.st)
      frc_pkg::HS_IDLE: begin
        q_d.div = 6'h00;
        // Words go out exactly as software set them
        if (go && PWDATA[1:0] == frc_pkg::KIND_REGISTER_WRITE_COMMAND &&
            PWDATA[9:8] <= frc_pkg::CNT_MAX) begin
          q_d.sh = {frc_pkg::REGISTER_WRITE_COMMAND_HI, PWDATA[7:4], 6'h00, PWDATA[9:8],
            q_q.data};
          q_d.nbits = frc_pkg::REGISTER_WRITE_COMMAND_BITS + {1'b0, PWDATA[9:8], 3'h0};
          q_d.csn = 1'b0;
          q_d.st = frc_pkg::HS_SHIFT;
        end else if (go && PWDATA[1:0] == frc_pkg::KIND_SYNC) begin
          q_d.sh = {frc_pkg::SYNC_OP, frc_pkg::SYNC_OP, 24'h000000};
          q_d.nbits = frc_pkg::SYNC_BITS;
          q_d.csn = 1'b0;
          q_d.st = frc_pkg::HS_SHIFT;
        end
      end
      frc_pkg::HS_SHIFT: begin
        // Bytes follow with no gap, within the byte spacing limit
        q_d.div = half ? 6'h00 : q_q.div + 6'h01;
        if (half) begin
          if (!q_q.sclk) begin
            q_d.sclk = 1'b1;
            q_d.din = q_q.sh[39];
            q_d.sh = {q_q.sh[38:0], 1'b0};
          end else begin
            q_d.sclk = 1'b0;
            q_d.nbits = q_q.nbits - 6'h01;
            if (q_q.nbits == 6'h01) begin
              q_d.gap = 11'h000;
              q_d.st = frc_pkg::HS_GAP;
            end
          end
        end
      end
      frc_pkg::HS_GAP: begin
        // Chip select rises half a bit late so the last bit lands
        q_d.gap = q_q.gap + 11'h001;
        if (q_q.gap == {5'h00, HALF_LAST}) begin
          q_d.csn = 1'b1;
        end
        if (q_q.gap == GAP_LAST) begin
          q_d.st = frc_pkg::HS_IDLE;
        end
      end
      default: q_d.st = frc_pkg::HS_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      q_q <= Q_RST;
    end else begin
      q_q <= q_d;
    end
  end

  assign PRDATA = q_q.prdata;
  assign PREADY = q_q.pready;
  assign PSLVERR = q_q.pslverr;
  assign LINK.sclk = q_q.sclk;
  assign LINK.cs_n = q_q.csn;
  assign LINK.din = q_q.din;
  assign LINK.start = q_q.start;
endmodule // frc_host
`default_nettype wire

/* File: tb/frc_checker.sv */
// Concurrent checks on the link, filter reset and APB timing
`timescale 1ns/10ps
`default_nettype none
module frc_checker #(
  parameter int RST_CYC = 64,
  parameter int MIN_CONV = 28
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // Link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic start,
  input wire logic drdy_n,
  // Converter outputs
  input wire logic FILT_RST_N,
  input wire logic RESULT_VALID,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY
);
  // Longest legal sclk half period in system clocks
  localparam int HALF_MAX = 32;
  int lo_q;
  int run_q;
  int hi_q;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      lo_q <= 0;
      run_q <= 0;
      hi_q <= 0;
    end else begin
      lo_q <= FILT_RST_N ? 0 : lo_q + 1;
      run_q <= (!FILT_RST_N || RESULT_VALID) ? 0 : run_q + 1;
      hi_q <= sclk ? hi_q + 1 : 0;
    end
  end
  rst_len_a: assert property (
    $rose(FILT_RST_N) |-> lo_q >= RST_CYC - 2)
    else $error("filter reset released early");
  conv_gap_a: assert property (
    RESULT_VALID |-> run_q >= MIN_CONV)
    else $error("conversion ended too soon");
  in_reset_a: assert property (
    !FILT_RST_N |-> !RESULT_VALID)
    else $error("result during filter reset");
  valid_once_a: assert property (RESULT_VALID |=> !RESULT_VALID)
    else $error("result valid longer than one cycle");
  drdy_set_a: assert property (
    RESULT_VALID |-> ##[0:1] !drdy_n)
    else $error("data ready missing after result");
  start_rst_a: assert property (
    $rose(start) |-> ##[1:16] !FILT_RST_N)
    else $error("start rise gave no filter reset");
  sclk_idle_a: assert property (cs_n |-> !sclk)
    else $error("serial clock moves while deselected");
  sclk_half_a: assert property (sclk |-> hi_q < HALF_MAX)
    else $error("serial clock half period too long");
  cs_gap_a: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("select gap too short");
  apb_wait_a: assert property (
    $rose(PENABLE) && PSEL |-> !PREADY ##1 PREADY)
    else $error("apb wait state wrong");
endmodule // frc_checker
`default_nettype wire

/* File: tb/test_filter_reset_and_cal_scaling.sv */
// Self-checking bench joining host and converter ends
`timescale 1ns/10ps
`default_nettype none
module test_filter_reset_and_cal_scaling;
  logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, er;
  logic wake, ofs_ld, gain_ld, rst_n_f, rvalid;
  logic [7:0] paddr, insel, bias, refc, grate;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] fdata, result;
  logic [23:0] cal_val, ofs_w, gain_w;
  int mismatches, check_count, lo, fst, nx;
  // Entries: filter data, offset, gain, expected code
  logic [79:0] sc [11] = '{
    80'h0000_7fffff_400000_8000, 80'h0000_000100_400000_ffff,
    80'h0000_000000_400000_0000, 80'h0000_ffff00_400000_0001,
    80'h0000_800000_400000_7fff, 80'h1000_000000_800000_2000,
    80'h1000_000000_200000_0800, 80'h1000_000000_000000_0000,
    80'h7000_000000_800000_7fff, 80'h9000_000000_800000_8000,
    80'h0300_000100_800000_05fe};
  frc_link_if link();
  // Short counts keep the run brief: reset 64 cycles, 60/40/30 counts
  frc_host #(.SCLK_HALF(4), .WR_GAP(64)) frc_host_i (.SYS_CLK(sys_clk),
    .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .LINK(link.host));
  frc_dev #(.FCLK_DIV(1), .MOD_DIV(2), .FIRST_CNT({10{20'h0003c}}),
    .SHORT_CNT({10{20'h00028}}), .NEXT_CNT({10{20'h0001e}})) frc_dev_i (
    .SYS_CLK(sys_clk), .RSTN(rstn), .LINK(link.dev), .FILT_DATA(fdata),
    .WAKE(wake), .CAL_OFS_LOAD(ofs_ld), .CAL_GAIN_LOAD(gain_ld),
    .CAL_VALUE(cal_val), .FILT_RST_N(rst_n_f), .RESULT(result),
    .RESULT_VALID(rvalid), .INPUT_SELECT(insel), .BIAS_VOLTAGE(bias),
    .REFERENCE_CONTROL(refc), .GAIN_RATE(grate), .OFFSET_WORD(ofs_w),
    .GAIN_WORD(gain_w));
  frc_checker frc_checker_i (
    .SYS_CLK(sys_clk), .RSTN(rstn), .sclk(link.sclk), .cs_n(link.cs_n),
    .start(link.start), .drdy_n(link.drdy_n), .FILT_RST_N(rst_n_f),
    .RESULT_VALID(rvalid), .PSEL(psel), .PENABLE(penable),
    .PREADY(pready));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic near(input int g, input int e);
    check(32'(g >= e - 2 && g <= e + 2), 32'h1);
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic frame(input logic [31:0] dat, input logic [31:0] cmd);
    int n;
    n = 0;
    // The host stores but never sends a command issued while busy
    do begin
      apb(1'b0, frc_pkg::APB_STAT, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 500);
    apb(1'b1, frc_pkg::APB_DATA, dat);
    apb(1'b1, frc_pkg::APB_CMD, cmd);
  endtask
  task automatic wres();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rvalid !== 1'b1 && n < 3000);
  endtask
  task automatic meas();
    int n;
    n = 0;
    while (rst_n_f !== 1'b0 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    lo = 0;
    while (rst_n_f === 1'b0 && lo < 3000) begin
      @(posedge sys_clk);
      lo++;
    end
    fst = 0;
    while (rvalid !== 1'b1 && fst < 3000) begin
      @(posedge sys_clk);
      fst++;
    end
    // Step past the pulse just seen so the next one is timed
    @(posedge sys_clk);
    nx = 0;
    while (rvalid !== 1'b1 && nx < 3000) begin
      @(posedge sys_clk);
      nx++;
    end
    wres();
  endtask
  task automatic t_reset();
    check(32'(ofs_w), 32'h0);
    check(32'(gain_w), 32'h400000);
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, er}, 32'h1);
    check(rd, 32'h0);
  endtask
  task automatic t_start();
    // Let the power-on filter hold end so the start rise is timed alone
    while (rst_n_f !== 1'b1) begin
      @(posedge sys_clk);
    end
    apb(1'b1, frc_pkg::APB_CTRL, 32'h1);
    meas();
    near(lo, 64);
    near(fst, 60);
    near(nx, 29);
    repeat (4) @(posedge sys_clk);
    apb(1'b0, frc_pkg::APB_STAT, 32'h0);
    check(rd, 32'h6);
  endtask
  task automatic t_cfg();
    frame(32'h5a0000, 32'h1);
    meas();
    check(32'(insel), 32'h5a);
    near(lo, 64);
    near(fst, 40);
    for (int a = 1; a < 4; a++) begin
      frame(32'(a + 8'h50) << 16, 32'(a << 4) | 32'h1);
      meas();
      near(lo, 64);
      near(fst, 60);
    end
    check(32'({bias, refc, grate}), 32'h515253);
    frame(32'h00a5c300, 32'h111);
    meas();
    check(32'(lo > 96), 32'h1);
    frame(32'h0, 32'h2);
    meas();
    near(fst, 40);
    @(posedge sys_clk);
    wake <= 1'b1;
    @(posedge sys_clk);
    wake <= 1'b0;
    meas();
    near(fst, 60);
  endtask
  task automatic t_scale();
    foreach (sc[i]) begin
      @(posedge sys_clk);
      fdata <= sc[i][79:64];
      cal_val <= sc[i][63:40];
      ofs_ld <= 1'b1;
      @(posedge sys_clk);
      cal_val <= sc[i][39:16];
      ofs_ld <= 1'b0;
      gain_ld <= 1'b1;
      @(posedge sys_clk);
      gain_ld <= 1'b0;
      wres();
      wres();
      check(32'(result), 32'(sc[i][15:0]));
    end
    // Host path: offset FFFF00h and unity gain, neither left from above
    frame(32'h00ffff, 32'h241);
    frame(32'h000040, 32'h271);
    fdata <= 16'h0;
    // Offset and gain writes do not reset the filter, so wait out the frame
    repeat (450) @(posedge sys_clk);
    wres();
    wres();
    check(32'(ofs_w), 32'hffff00);
    check(32'(gain_w), 32'h400000);
    check(32'(result), 32'h0001);
  endtask
  task automatic end_sim();
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    #700000;
    mismatches++;
    end_sim();
  end
  initial begin
    {rstn, psel, penable, pwrite, wake, ofs_ld, gain_ld} = '0;
    {paddr, pwdata, fdata, cal_val} = '0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_start();
    t_cfg();
    t_scale();
    end_sim();
  end
endmodule // test_filter_reset_and_cal_scaling
`default_nettype wire
